// ===== common/pot_pkg.sv
// Purpose: Shared constants and state types for the dual wiper serial link
// Assumes: Both link ends and the bench import this package
// Notes:   Address prefix and midscale are fixed by the part family
package pot_pkg;
	localparam int         WIPER_W     = 8;
	localparam int         BYTE_BITS   = 8;
	localparam logic [4:0] ADDR_PREFIX = 5'h0B;
	localparam logic [1:0] FIXED_LOW   = 2'h3;
	localparam logic [7:0] MIDSCALE    = 8'h80;
	localparam logic [7:0] ZERO_CODE   = 8'h00;
	localparam int         SEL_POS     = 7;
	localparam int         SD_POS      = 6;
	localparam logic [3:0] LAST_BIT    = 4'h7;
	localparam logic [3:0] ACK_SLOT    = 4'h8;
	localparam int         QTR_DEFAULT = 4;
	localparam int         QTR_MIN     = 3;

	typedef enum {D_ADDR, D_INSTR, D_WDATA, D_RDATA, D_IGNORE} dev_state_t;
	typedef enum {H_IDLE, H_START, H_BIT, H_STOP} host_state_t;
endpackage : pot_pkg

// ===== common/pot_link_if.sv
// Purpose: Two-wire link between bus master and wiper device
// Assumes: Data line is open drain with a pull-up
// Notes:   Clock line is driven push-pull by the master
`timescale 1ns/1ns
interface pot_link_if;
	logic scl;
	logic m_sda_out;
	logic m_sda_oe_n;
	logic s_sda_out;
	logic s_sda_oe_n;
	logic sda;

	// Wired-AND with pull-up
	assign sda = !((!m_sda_oe_n && !m_sda_out) || (!s_sda_oe_n && !s_sda_out));

	modport master (output scl, output m_sda_out, output m_sda_oe_n, input sda);
	modport slave  (input scl, input sda, output s_sda_out, output s_sda_oe_n);
endinterface : pot_link_if

// ===== logic/pot_slave.sv
// Purpose: Serial slave for a dual 256-position wiper with shutdown
// Assumes: Link logic runs on the bus clock, latches on clk
// Notes:   Strap pins and latch words are quasi-static across domains
//
// What this block does
// - Master opens every transfer with start
// - Address byte: seven bits then direction
// - Matching address acknowledged on ninth pulse
// - Mismatch stays silent until next start
// - Fixed address or two strapped bits
// - Address is 01011 plus two low bits
// - Instruction MSB picks channel one or two
// - Shutdown opens A, wiper to B
// - Shutdown still accepts values, restores on exit
// - Six low instruction bits ignored
// - Bytes are nine clocks, MSB first
// - Data changes only while clock low
// - Read data follows address ack directly
// - Read returns last selected channel's latch
// - Instruction-only write still updates selection
// - Master ends transfer with stop
// - Write ends with release for stop
// - Read ends with nack then stop
// - Every further data byte updates latch
// - New instruction needs a new transfer
// - Acked reads keep sending selected value
// - Both latches preset to midscale
// - Eight-bit latch per channel
`timescale 1ns/1ns
module pot_slave
	import pot_pkg::*;
#(
	parameter bit STRAPPED = 1'b1
) (
	// System side
	input  wire logic               clk,
	input  wire logic               rst,
	// Address straps
	input  wire logic               addr_pin_0,
	input  wire logic               addr_pin_1,
	// Link
	pot_link_if.slave               link,
	// Wiper state
	output logic [WIPER_W-1:0]      wiper_latch_1,
	output logic [WIPER_W-1:0]      wiper_latch_2,
	output logic [WIPER_W-1:0]      applied_code_1,
	output logic [WIPER_W-1:0]      applied_code_2,
	output logic                    shutdown_active
);
	import pot_pkg::*;

	if (WIPER_W != BYTE_BITS) begin : g_bad_width
		$error("wiper width must equal byte width");
	end

	// Clock domain of clk
	logic [1:0]         strap_meta;
	logic [1:0]         strap_sync;
	logic [1:0]         addr_low;
	logic [2:0]         ins_sync;
	logic [2:0]         dat_sync;
	logic               sel;
	logic [7:0]         rd_value;

	// Clock domain of the link
	logic               start_tog;
	logic               stop_tog;
	logic               start_seen;
	logic               stop_seen;
	dev_state_t         state;
	logic [3:0]         bit_cnt;
	logic [7:0]         shift;
	logic [7:0]         tx;
	logic               rw;
	logic               ack;
	logic               drv;
	logic               ins_tog;
	logic               ins_sel_q;
	logic               ins_sd_q;
	logic               dat_tog;
	logic [7:0]         dat_q;

	logic               fresh;
	logic               stopped;
	logic [7:0]         byte_in;
	logic [2:0]         tx_idx;
	logic [6:0]         own_addr;
	logic               ins_evt;
	logic               dat_evt;

	always_ff @(posedge clk) begin
		strap_meta <= {addr_pin_1, addr_pin_0};
		strap_sync <= strap_meta;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			addr_low <= FIXED_LOW;
		end else begin
			addr_low <= STRAPPED ? strap_sync : FIXED_LOW;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ins_sync <= 3'h0;
			dat_sync <= 3'h0;
		end else begin
			ins_sync <= {ins_sync[1:0], ins_tog};
			dat_sync <= {dat_sync[1:0], dat_tog};
		end
	end

	assign ins_evt = ins_sync[2] ^ ins_sync[1];
	assign dat_evt = dat_sync[2] ^ dat_sync[1];

	always_ff @(posedge clk) begin
		if (rst) begin
			wiper_latch_1   <= MIDSCALE;
			wiper_latch_2   <= MIDSCALE;
			sel             <= 1'b0;
			shutdown_active <= 1'b0;
		end else begin
			if (ins_evt) begin
				sel             <= ins_sel_q;
				shutdown_active <= ins_sd_q;
			end
			if (dat_evt) begin
				if (sel) begin
					wiper_latch_2 <= dat_q;
				end else begin
					wiper_latch_1 <= dat_q;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			applied_code_1 <= MIDSCALE;
			applied_code_2 <= MIDSCALE;
		end else begin
			applied_code_1 <= shutdown_active ? ZERO_CODE : wiper_latch_1;
			applied_code_2 <= shutdown_active ? ZERO_CODE : wiper_latch_2;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rd_value <= MIDSCALE;
		end else begin
			rd_value <= sel ? wiper_latch_2 : wiper_latch_1;
		end
	end

	// Link side: start and stop seen on data edges
	// start while clock high
	always_ff @(negedge link.sda or posedge rst) begin
		if (rst) begin
			start_tog <= 1'b0;
		end else if (link.scl) begin
			start_tog <= ~start_tog;
		end
	end

	always_ff @(posedge link.sda or posedge rst) begin
		if (rst) begin
			stop_tog <= 1'b0;
		end else if (link.scl) begin
			stop_tog <= ~stop_tog;
		end
	end

	assign own_addr = {ADDR_PREFIX, addr_low};
	assign fresh    = start_tog != start_seen;
	assign stopped  = stop_tog != stop_seen;
	assign byte_in  = {shift[6:0], link.sda};
	assign tx_idx   = 3'(LAST_BIT - bit_cnt);

	always_ff @(posedge link.scl or posedge rst) begin
		if (rst) begin
			start_seen <= 1'b0;
			stop_seen  <= 1'b0;
		end else begin
			start_seen <= start_tog;
			stop_seen  <= stop_tog;
		end
	end

	always_ff @(posedge link.scl or posedge rst) begin
		if (rst) begin
			state   <= D_IGNORE;
			bit_cnt <= 4'h0;
			shift   <= 8'h00;
			tx      <= 8'h00;
			rw      <= 1'b0;
			ack     <= 1'b0;
		end else if (fresh) begin
			state   <= D_ADDR;
			bit_cnt <= 4'h1;
			shift   <= byte_in;
			ack     <= 1'b0;
		end else if (stopped) begin
			state   <= D_IGNORE;
			bit_cnt <= 4'h0;
			ack     <= 1'b0;
		end else if (state == D_IGNORE) begin
			ack     <= 1'b0;
		end else if (bit_cnt == ACK_SLOT) begin
			bit_cnt <= 4'h0;
			ack     <= 1'b0;
			unique case (state)
				D_ADDR: begin
					state <= rw ? D_RDATA : D_INSTR;
					tx    <= rd_value;
				end
				D_INSTR: state <= D_WDATA;
				D_WDATA: state <= D_WDATA;
				D_RDATA: begin
					if (link.sda) begin
						state <= D_IGNORE;
					end else begin
						tx <= rd_value;
					end
				end
				D_IGNORE: state <= D_IGNORE;
			endcase
		end else begin
			shift   <= byte_in;
			bit_cnt <= bit_cnt + 4'h1;
			if (bit_cnt == LAST_BIT) begin
				unique case (state)
					D_ADDR: begin
						if (byte_in[7:1] == own_addr) begin
							ack <= 1'b1;
							rw  <= byte_in[0];
						end else begin
							state <= D_IGNORE;
						end
					end
					D_INSTR: ack <= 1'b1;
					D_WDATA: ack <= 1'b1;
					D_RDATA: ack <= 1'b0;
					D_IGNORE: ack <= 1'b0;
				endcase
			end
		end
	end

	// Byte events handed to clk domain
	always_ff @(posedge link.scl or posedge rst) begin
		if (rst) begin
			ins_tog   <= 1'b0;
			ins_sel_q <= 1'b0;
			ins_sd_q  <= 1'b0;
			dat_tog   <= 1'b0;
			dat_q     <= MIDSCALE;
		end else if (!fresh && !stopped && bit_cnt == LAST_BIT) begin
			if (state == D_INSTR) begin
				ins_sel_q <= byte_in[SEL_POS];
				ins_sd_q  <= byte_in[SD_POS];
				ins_tog   <= ~ins_tog;
			end else if (state == D_WDATA) begin
				dat_q   <= byte_in;
				dat_tog <= ~dat_tog;
			end
		end
	end

	always_ff @(negedge link.scl or posedge rst) begin
		if (rst) begin
			drv <= 1'b0;
		end else begin
			drv <= (bit_cnt == ACK_SLOT && ack) ||
				(state == D_RDATA && bit_cnt != ACK_SLOT && !tx[tx_idx]);
		end
	end

	assign link.s_sda_out  = 1'b0;
	assign link.s_sda_oe_n = ~drv;
endmodule : pot_slave

// ===== logic/pot_master.sv
// Purpose: Bus master that writes and reads the dual wiper device
// Assumes: One command at a time, data bytes streamed on request
// Notes:   Link clock period is four quarters of QTR clk cycles
`timescale 1ns/1ns
module pot_master
	import pot_pkg::*;
#(
	parameter int QTR = QTR_DEFAULT
) (
	// System side
	input  wire logic          clk,
	input  wire logic          rst,
	// Command
	input  wire logic          cmd_valid,
	output logic               cmd_ready,
	input  wire logic          cmd_read,
	input  wire logic [6:0]    cmd_addr,
	input  wire logic [7:0]    cmd_instr,
	input  wire logic [3:0]    cmd_len,
	// Write data
	input  wire logic [7:0]    wr_data,
	output logic               wr_take,
	// Read data and status
	output logic [7:0]         rd_data,
	output logic               rd_valid,
	output logic               done,
	output logic               nacked,
	// Link
	pot_link_if.master         link
);
	import pot_pkg::*;

	localparam int QW = $clog2(QTR);

	if (QTR < QTR_MIN) begin : g_bad_qtr
		$error("QTR too small for the data line synchroniser");
	end

	host_state_t      st;
	logic [QW-1:0]    q_cnt;
	logic             tick;
	logic [1:0]       ph;
	logic [3:0]       bit_no;
	logic             first;
	logic             rd_mode;
	logic [3:0]       left;
	logic [7:0]       instr;
	logic [7:0]       tx;
	logic [7:0]       rx;
	logic             abort;
	logic             scl_q;
	logic             sda_low;
	logic             sda_meta;
	logic             sda_s;
	logic             sending;

	assign cmd_ready = (st == H_IDLE) && !rst;
	assign tick      = q_cnt == QW'(QTR - 1);
	assign sending   = !(rd_mode && !first);

	always_ff @(posedge clk) begin
		sda_meta <= link.sda;
		sda_s    <= sda_meta;
	end

	always_ff @(posedge clk) begin
		if (rst || st == H_IDLE || tick) begin
			q_cnt <= '0;
		end else begin
			q_cnt <= q_cnt + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st <= H_IDLE; ph <= 2'h0; bit_no <= 4'h0; first <= 1'b1;
			rd_mode <= 1'b0; left <= 4'h0; instr <= 8'h00; tx <= 8'h00;
			rx <= 8'h00; abort <= 1'b0; scl_q <= 1'b1; sda_low <= 1'b0;
			rd_data <= 8'h00; rd_valid <= 1'b0; wr_take <= 1'b0;
			done <= 1'b0; nacked <= 1'b0;
		end else begin
			rd_valid <= 1'b0;
			wr_take  <= 1'b0;
			done     <= 1'b0;
			if (st == H_IDLE) begin
				if (cmd_valid) begin
					st      <= H_START;
					ph      <= 2'h0;
					rd_mode <= cmd_read;
					left    <= cmd_len;
					instr   <= cmd_instr;
					tx      <= {cmd_addr, cmd_read};
					first   <= 1'b1;
					abort   <= 1'b0;
					nacked  <= 1'b0;
				end
			end else if (tick) begin
				ph <= ph + 2'h1;
				unique case (st)
					H_START: begin
						if (ph == 2'h1) sda_low <= 1'b1;
						if (ph == 2'h2) scl_q <= 1'b0;
						if (ph == 2'h3) begin
							st      <= H_BIT;
							bit_no  <= 4'h0;
							sda_low <= ~tx[7];
						end
					end
					H_BIT: begin
						if (ph == 2'h0) scl_q <= 1'b1;
						if (ph == 2'h2) begin
							scl_q <= 1'b0;
							if (bit_no != ACK_SLOT) begin
								rx <= {rx[6:0], sda_s};
							end else if (sending) begin
								abort <= sda_s;
							end else begin
								rd_data  <= rx;
								rd_valid <= 1'b1;
							end
						end
						if (ph == 2'h3) begin
							if (bit_no == LAST_BIT) begin
								bit_no  <= ACK_SLOT;
								sda_low <= sending ? 1'b0 : (left > 4'h1);
							end else if (bit_no != ACK_SLOT) begin
								bit_no  <= bit_no + 4'h1;
								tx      <= {tx[6:0], 1'b0};
								sda_low <= sending ? ~tx[6] : 1'b0;
							end else begin
								bit_no <= 4'h0;
								first  <= 1'b0;
								if (abort) begin
									st <= H_STOP; sda_low <= 1'b1; nacked <= 1'b1;
								end else if (first && !rd_mode) begin
									tx <= instr; sda_low <= ~instr[7];
								end else if (!(rd_mode && first) &&
									(left == 4'h0 || (rd_mode && left == 4'h1))) begin
									st <= H_STOP; sda_low <= 1'b1;
									left <= 4'h0;
								end else if (rd_mode) begin
									left <= first ? left : left - 4'h1;
									sda_low <= 1'b0;
								end else begin
									tx <= wr_data; wr_take <= 1'b1;
									left <= left - 4'h1; sda_low <= ~wr_data[7];
								end
							end
						end
					end
					H_STOP: begin
						if (ph == 2'h0) scl_q <= 1'b1;
						if (ph == 2'h1) sda_low <= 1'b0;
						if (ph == 2'h3) begin
							st <= H_IDLE; done <= 1'b1;
						end
					end
					H_IDLE: st <= H_IDLE;
				endcase
			end
		end
	end

	assign link.scl        = scl_q;
	assign link.m_sda_out  = 1'b0;
	assign link.m_sda_oe_n = ~sda_low;
endmodule : pot_master

// ===== sim/dual_pot_i2c_slave_assertions.sv
// Purpose: Link-level checks beside the wiper serial link
// Assumes: Link signals sampled on clk, master makes scl
// Notes:   Bit and byte counts follow scl rises after start
`timescale 1ns/1ns
module dual_pot_i2c_slave_assertions
	import pot_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Link
	input  wire logic scl,
	input  wire logic m_sda_out,
	input  wire logic m_sda_oe_n,
	input  wire logic s_sda_out,
	input  wire logic s_sda_oe_n,
	input  wire logic sda,
	// Straps
	input  wire logic addr_pin_0,
	input  wire logic addr_pin_1
);
	import pot_pkg::*;
	logic       scl_d, sda_d, busy, rw, matched;
	logic [3:0] bitn, byten;
	logic [7:0] shreg;
	wire        rise  = scl && !scl_d;
	wire        start = scl && scl_d && sda_d && !sda;
	wire        stop  = scl && scl_d && !sda_d && sda;
	wire [6:0]  own   = {ADDR_PREFIX, addr_pin_1, addr_pin_0};

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	always_ff @(posedge clk) begin
		scl_d <= scl;
		sda_d <= sda;
		busy  <= !rst && !stop && (busy || start);
	end
	always_ff @(posedge clk) begin
		if (rst || start) begin
			bitn  <= 4'h0;
			byten <= 4'h0;
			shreg <= 8'h00;
		end else if (rise) begin
			bitn  <= (bitn == ACK_SLOT) ? 4'h0 : bitn + 4'h1;
			byten <= (bitn == ACK_SLOT && byten != 4'hF) ? byten + 4'h1 : byten;
			shreg <= {shreg[6:0], sda};
		end
	end
	always_ff @(posedge clk) begin
		if (rise && byten == 4'h0 && bitn == ACK_SLOT) begin
			matched <= (shreg[7:1] == own);
			rw      <= shreg[0];
		end
	end

	a_slave_sda_stable: assert property (scl && scl_d |-> $stable(s_sda_oe_n))
		else $error("slave moved sda while scl high");
	a_idle_released: assert property (!busy |-> s_sda_oe_n)
		else $error("slave drives sda outside a transfer");
	a_addr_no_early: assert property (busy && byten == 4'h0 && bitn < ACK_SLOT |-> s_sda_oe_n)
		else $error("slave drives sda during address bits");
	a_ack_on_match: assert property ($fell(scl) && byten == 4'h0 && bitn == ACK_SLOT
		&& shreg[7:1] == own |-> ##[0:2] !s_sda_oe_n)
		else $error("own address not acknowledged");
	a_silent_mismatch: assert property ($fell(scl) && byten == 4'h0 && bitn == ACK_SLOT
		&& shreg[7:1] != own |-> s_sda_oe_n [*8])
		else $error("foreign address acknowledged");
	a_ack_instr: assert property ($fell(scl) && byten == 4'h1 && bitn == ACK_SLOT
		&& matched && !rw |-> ##[0:2] !s_sda_oe_n)
		else $error("instruction byte not acknowledged");
	a_write_quiet: assert property (busy && matched && !rw && byten != 4'h0
		&& bitn != 4'h0 && bitn != ACK_SLOT |-> s_sda_oe_n)
		else $error("slave drives sda during written data bits");
	a_read_release: assert property ($fell(scl) && busy && matched && rw
		&& byten != 4'h0 && bitn == ACK_SLOT |-> ##[0:2] s_sda_oe_n)
		else $error("slave holds sda in master ack slot");

	c_write_data: cover property ($fell(scl) && byten == 4'h2 && bitn == ACK_SLOT && !rw);
	c_read_mode: cover property (busy && matched && rw && byten == 4'h2);
	c_mismatch: cover property (rise && byten == 4'h0 && bitn == ACK_SLOT && shreg[7:1] != own);
endmodule : dual_pot_i2c_slave_assertions

// ===== sim/dual_pot_i2c_slave_tb.sv
// Purpose: Self-checking bench for both link ends
// Assumes: Master and slave joined by the link interface
// Notes:   Bench keeps its own model of latches and selection
`timescale 1ns/1ns
module dual_pot_i2c_slave_tb;
	import pot_pkg::*;
	logic       clk, rst, cmd_valid, cmd_read, addr_pin_0, addr_pin_1;
	logic       cmd_ready, wr_take, rd_valid, done, nacked, shutdown_active, sel, sd;
	logic [6:0] cmd_addr;
	logic [7:0] cmd_instr, wr_data, rd_data, ins;
	logic [3:0] cmd_len, n;
	logic [7:0] wiper_latch_1, wiper_latch_2, applied_code_1, applied_code_2;
	logic [7:0] lat [2];
	logic [7:0] wbuf [16];
	logic [7:0] rbuf [16];
	int         mismatches, n_tests, seed_dummy, n_rd;

	pot_link_if link ();
	pot_master #(.QTR(QTR_DEFAULT)) pot_master_inst (.clk, .rst, .cmd_valid, .cmd_ready,
		.cmd_read, .cmd_addr, .cmd_instr, .cmd_len, .wr_data, .wr_take, .rd_data,
		.rd_valid, .done, .nacked, .link(link));
	pot_slave #(.STRAPPED(1'b1)) pot_slave_inst (.clk, .rst, .addr_pin_0, .addr_pin_1,
		.link(link), .wiper_latch_1, .wiper_latch_2, .applied_code_1, .applied_code_2,
		.shutdown_active);
	dual_pot_i2c_slave_assertions dual_pot_i2c_slave_assertions_inst (.clk, .rst,
		.scl(link.scl), .m_sda_out(link.m_sda_out), .m_sda_oe_n(link.m_sda_oe_n),
		.s_sda_out(link.s_sda_out), .s_sda_oe_n(link.s_sda_oe_n), .sda(link.sda),
		.addr_pin_0, .addr_pin_1);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	function automatic logic [7:0] shown(input logic [7:0] l, input logic s);
		return s ? ZERO_CODE : l;
	endfunction : shown
	function automatic logic [6:0] own(input logic p1, input logic p0);
		return {ADDR_PREFIX, p1, p0};
	endfunction : own

	task automatic summarize();
		$display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			mismatches++;
		end
	endtask : chk

	// One whole frame: command, write data on request, read data collected
	task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] i,
		input logic [3:0] k);
		int t;
		int w;
		int r;
		t = 0;
		w = 0;
		r = 0;
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_read  <= rd;
		cmd_addr  <= a;
		cmd_instr <= i;
		cmd_len   <= k;
		wr_data   <= wbuf[0];
		do begin
			@(posedge clk);
			t++;
		end while (cmd_ready !== 1'b1 && t < 100);
		cmd_valid <= 1'b0;
		while (done !== 1'b1 && t < 20000) begin
			@(posedge clk);
			t++;
			if (wr_take === 1'b1) begin
				w++;
				wr_data <= wbuf[w % 16];
			end
			if (rd_valid === 1'b1) begin
				rbuf[r % 16] = rd_data;
				r++;
			end
		end
		if (t >= 20000) begin
			mismatches++;
			summarize();
		end
		n_rd = r;
		repeat (3) @(posedge clk);
	endtask : xfer

	task automatic check_state();
		chk(wiper_latch_1, lat[0]);
		chk(wiper_latch_2, lat[1]);
		chk(applied_code_1, shown(lat[0], sd));
		chk(applied_code_2, shown(lat[1], sd));
		chk({7'h00, shutdown_active}, {7'h00, sd});
	endtask : check_state

	task automatic wr(input logic [7:0] i, input logic [3:0] k);
		xfer(1'b0, own(addr_pin_1, addr_pin_0), i, k);
		sel = i[SEL_POS];
		sd  = i[SD_POS];
		if (k != 4'h0)
			lat[sel] = wbuf[k - 4'h1];
		chk({7'h00, nacked}, 8'h00);
		check_state();
	endtask : wr

	task automatic rd(input logic [3:0] k);
		xfer(1'b1, own(addr_pin_1, addr_pin_0), 8'h00, k);
		chk(8'(n_rd), {4'h0, k});
		for (int j = 0; j < k; j++)
			chk(rbuf[j], lat[sel]);
	endtask : rd

	initial begin
		rst        = 1'b1;
		cmd_valid  = 1'b0;
		cmd_read   = 1'b0;
		cmd_addr   = 7'h00;
		cmd_instr  = 8'h00;
		cmd_len    = 4'h0;
		wr_data    = 8'h00;
		addr_pin_0 = 1'b0;
		addr_pin_1 = 1'b1;
		mismatches = 0;
		n_tests    = 0;
		sel        = 1'b0;
		sd         = 1'b0;
		lat[0]     = MIDSCALE;
		lat[1]     = MIDSCALE;
		seed_dummy = $urandom(64);
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		check_state();
		// Boundary codes, don't-care bits, multi-byte write, repeated read
		wbuf[0] = 8'hFF;
		wr(8'h3F, 4'h1);
		wbuf[0] = 8'h00;
		wbuf[1] = 8'h5A;
		wbuf[2] = 8'hA5;
		wr(8'h80, 4'h3);
		rd(4'h3);
		// Shutdown accepts values, exit without data, instruction-only select
		wbuf[0] = 8'h11;
		wr(8'h40, 4'h1);
		wr(8'h80, 4'h0);
		rd(4'h1);
		wr(8'h00, 4'h0);
		rd(4'h1);
		// Foreign address leaves everything alone
		xfer(1'b0, own(!addr_pin_1, addr_pin_0), 8'hC0, 4'h1);
		chk({7'h00, nacked}, 8'h01);
		check_state();
		repeat (24) begin
			{addr_pin_1, addr_pin_0} <= 2'($urandom);
			repeat (4) @(posedge clk);
			ins = 8'($urandom);
			n   = 4'($urandom_range(3));
			for (int j = 0; j < 16; j++)
				wbuf[j] = 8'($urandom);
			if ($urandom_range(1) == 1)
				rd(n + 4'h1);
			else
				wr(ins, n);
		end
		summarize();
	end
endmodule : dual_pot_i2c_slave_tb
